// [sdb_pkg.sv]
package sdb_pkg;

   // AHB transfer type and burst encodings
   localparam logic [1:0] TRANS_IDLE   = 2'h0;
   localparam logic [1:0] TRANS_BUSY   = 2'h1;
   localparam logic [1:0] TRANS_NONSEQ = 2'h2;
   localparam logic [1:0] TRANS_SEQ    = 2'h3;
   localparam logic [2:0] BURST_SINGLE = 3'h0;
   localparam logic [2:0] BURST_INCR   = 3'h1;
   localparam int         HPROT_BUF_BIT = 2;

   // Beats after the first one of fixed-length bursts
   localparam logic [3:0] BEATS4_LAST  = 4'h3;
   localparam logic [3:0] BEATS8_LAST  = 4'h7;
   localparam logic [3:0] BEATS16_LAST = 4'hf;

   // Register map
   localparam int          APB_AW     = 12;
   localparam logic [11:0] STATUS_OFF = 12'h000;
   localparam logic [11:0] MASK_OFF   = 12'h004;
   localparam logic [11:0] STATE_OFF  = 12'h008;

   // Event bits of status and mask
   localparam int         EV_W        = 2;
   localparam int         EV_BWF_BIT  = 0;
   localparam int         EV_PERR_BIT = 1;
   localparam logic [1:0] STATUS_RST  = 2'h0;
   localparam logic [1:0] MASK_RST    = 2'h0;

   // Bits of the state register
   localparam int ST_HOLD_BIT = 0;
   localparam int ST_BUSY_BIT = 1;
   localparam int ST_PEND_BIT = 2;

   typedef enum logic [1:0] {
      SL_IDLE = 2'b00,
      SL_ADDR = 2'b01,
      SL_DATA = 2'b11
   } sdb_slow_state_t;

   typedef enum logic [1:0] {
      ER_IDLE = 2'b00,
      ER_WAIT = 2'b01,
      ER_DONE = 2'b11
   } sdb_err_state_t;

endpackage

// [sdb_hold_stage.sv]
`timescale 1ns/100ps
module sdb_hold_stage #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Capture and release
   input  wire logic         load,
   input  wire logic [W-1:0] cap,
   input  wire logic         take,
   // Held transfer
   output logic [W-1:0]      vec,
   output logic              valid
);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         valid <= 1'b0;
         vec   <= '0;
      end else if (load) begin
         valid <= 1'b1;
         vec   <= cap;
      end else if (take) begin
         valid <= 1'b0;
      end
   end

endmodule

// [sdb_err_resp.sv]
`timescale 1ns/100ps
module sdb_err_resp (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Slow side error seen
   input  wire logic start,
   // Fast side two-cycle error response
   output logic      resp,
   output logic      ready
);

   sdb_pkg::sdb_err_state_t st;
   sdb_pkg::sdb_err_state_t next_st;

   always_comb begin
      case (st)
         sdb_pkg::ER_IDLE: next_st = start ? sdb_pkg::ER_WAIT : sdb_pkg::ER_IDLE;
         sdb_pkg::ER_WAIT: next_st = sdb_pkg::ER_DONE;
         default:          next_st = sdb_pkg::ER_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= sdb_pkg::ER_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign resp  = (st != sdb_pkg::ER_IDLE);
   assign ready = (st == sdb_pkg::ER_DONE);

endmodule

// [sdb_bridge.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - With the write buffer present, HPROT[2] of each write picks buffered or pass-through.
// - Fast-side address and control are registered before they reach the slow bus.
// - Read data and ready return combinationally, error responses from registers.
// - A buffered write that fails downstream gives a fault pulse of one fast cycle.
// - With burst support off (default) bursts leave as single transfers.
// - With burst support on, bursts are forwarded as bursts.
// - The write buffer parameter at 1 builds a one-entry buffer, at 0 (default) none.
// - Address width defaults to 32 bits and master id width to 1 bit.
// - Data width is 32 (default) or 64 bits.
// - Slow-side activity advances only on fast edges marked by the slow clock enable.
// - With the enable tied high both sides run together, with two extra forward cycles.
// - A bufferable write that is not held is answered OKAY at once and written downstream later.
// - Writes with HPROT[2] high are bufferable, reads never are.
// - A transfer arriving during a buffered write is held with wait states, then issued.
module sdb_bridge #(
   parameter int address_width_param   = 32,
   parameter int master_id_width_param = 1,
   parameter int data_width_param      = 32,
   parameter int burst_support_param   = 0,
   parameter int write_buffer_param    = 0
) (
   // Clock and reset
   input  wire logic                             MCLK,
   input  wire logic                             RST_N,
   input  wire logic                             SLOW_BUS_CLOCK_ENABLE,
   // Fast side, AHB-Lite slave
   input  wire logic                             HSELS,
   input  wire logic [address_width_param-1:0]   HADDRS,
   input  wire logic [1:0]                       HTRANSS,
   input  wire logic [2:0]                       HSIZES,
   input  wire logic [2:0]                       HBURSTS,
   input  wire logic [3:0]                       HPROTS,
   input  wire logic [master_id_width_param-1:0] HMASTERS,
   input  wire logic                             HWRITES,
   input  wire logic                             HMASTLOCKS,
   input  wire logic [data_width_param-1:0]      HWDATAS,
   input  wire logic                             HREADYS,
   output logic                                  HREADYOUTS,
   output logic                                  HRESPS,
   output logic [data_width_param-1:0]           HRDATAS,
   output logic                                  BUFFERED_WRITE_FAULT_PULSE,
   // Slow side, AHB-Lite master
   output logic [address_width_param-1:0]        HADDRM,
   output logic [1:0]                            HTRANSM,
   output logic [2:0]                            HSIZEM,
   output logic [2:0]                            HBURSTM,
   output logic [3:0]                            HPROTM,
   output logic [master_id_width_param-1:0]      HMASTERM,
   output logic                                  HWRITEM,
   output logic                                  HMASTLOCKM,
   output logic [data_width_param-1:0]           HWDATAM,
   input  wire logic [data_width_param-1:0]      HRDATAM,
   input  wire logic                             HREADYM,
   input  wire logic                             HRESPM,
   // APB register port
   input  wire logic                             PSEL,
   input  wire logic                             PENABLE,
   input  wire logic                             PWRITE,
   input  wire logic [sdb_pkg::APB_AW-1:0]       PADDR,
   input  wire logic [31:0]                      PWDATA,
   input  wire logic [3:0]                       PSTRB,
   output logic                                  PREADY,
   output logic [31:0]                           PRDATA,
   output logic                                  PSLVERR,
   // Interrupt
   output logic                                  INTERRUPT
);

   localparam int AW = address_width_param;
   localparam int MW = master_id_width_param;
   localparam int CW = AW + MW + 15;

   // Transfer descriptors
   logic [CW-1:0]           cap_vec;
   logic [CW-1:0]           cur_vec;
   logic [CW-1:0]           hld_vec;
   logic                    hld_valid;
   logic [AW-1:0]           c_addr;
   logic [2:0]              c_size;
   logic [2:0]              c_burst;
   logic [3:0]              c_prot;
   logic [MW-1:0]           c_master;
   logic                    c_write;
   logic                    c_lock;
   logic [1:0]              c_trans;
   logic                    c_buf;

   // Slow side state
   sdb_pkg::sdb_slow_state_t st;
   logic                    pend;
   logic [3:0]              rem;
   logic [data_width_param-1:0] wdata;

   // Fast data phase tracking
   logic                    fdp;
   logic                    fdp_buf;
   logic                    fdp_held;
   logic                    fdp_write;
   logic                    err_resp;
   logic                    err_rdy;

   // Registers
   logic [sdb_pkg::EV_W-1:0] status;
   logic [sdb_pkg::EV_W-1:0] mask;
   logic [sdb_pkg::EV_W-1:0] next_status;

   // Decode of the fast and slow sides
   wire logic cap_buf  = (write_buffer_param == 1) && HWRITES
                         && HPROTS[sdb_pkg::HPROT_BUF_BIT];
   wire logic acc      = HSELS && HTRANSS[1] && HREADYS;
   wire logic en       = SLOW_BUS_CLOCK_ENABLE;
   wire logic in_data  = (st == sdb_pkg::SL_DATA);
   wire logic fin      = in_data && en && (HREADYM || HRESPM);
   wire logic fin_ok   = in_data && en && HREADYM;
   wire logic fin_err  = in_data && en && HRESPM && !HREADYM;
   wire logic busy     = pend || hld_valid || ((st != sdb_pkg::SL_IDLE) && !fin);
   wire logic load_cur = acc && !busy;
   wire logic hld_load = acc && busy;
   wire logic hld_take = hld_valid && !pend && (st == sdb_pkg::SL_IDLE);
   wire logic issue    = en && (st == sdb_pkg::SL_IDLE) && pend;
   wire logic ev_bwf   = fin_err && c_buf;
   wire logic ev_perr  = fin_err && !c_buf;

   assign cap_vec = {HADDRS, HSIZES, HBURSTS, HPROTS, HMASTERS, HWRITES, HMASTLOCKS,
                     HTRANSS, cap_buf};
   assign {c_addr, c_size, c_burst, c_prot, c_master, c_write, c_lock, c_trans,
           c_buf} = cur_vec;

   // Burst length bookkeeping for forwarded bursts
   wire logic       fixed_burst = (c_burst[2:1] != 2'h0);
   wire logic [3:0] first_rem   = (c_burst[2:1] == 2'h1) ? sdb_pkg::BEATS4_LAST :
                                  (c_burst[2:1] == 2'h2) ? sdb_pkg::BEATS8_LAST :
                                  (c_burst[2:1] == 2'h3) ? sdb_pkg::BEATS16_LAST : 4'h0;
   wire logic [3:0] next_rem    = (c_trans == sdb_pkg::TRANS_NONSEQ) ? first_rem
                                                                     : rem - 4'h1;
   wire logic       gap_busy    = (burst_support_param == 1)
                                  && ((c_burst == sdb_pkg::BURST_INCR)
                                      || (fixed_burst && (rem != 4'h0)));

   // Issued transfer type and burst
   wire logic [1:0] issue_trans = (burst_support_param == 1) ? c_trans
                                                             : sdb_pkg::TRANS_NONSEQ;
   wire logic [2:0] issue_burst = (burst_support_param == 1) ? c_burst
                                                             : sdb_pkg::BURST_SINGLE;

   // Fast side response, combinational except errors
   assign HREADYOUTS = err_resp ? err_rdy
                     : (!fdp || (!fdp_held && (fdp_buf || fin_ok)));
   assign HRDATAS    = HRDATAM;
   assign HRESPS     = err_resp;

   generate
      if (write_buffer_param == 1) begin : g_wb
         sdb_hold_stage #(
            .W     (CW)
         ) u_hold (
            .clk   (MCLK),
            .rst_n (RST_N),
            .load  (hld_load),
            .cap   (cap_vec),
            .take  (hld_take),
            .vec   (hld_vec),
            .valid (hld_valid)
         );
      end else begin : g_nowb
         assign hld_vec   = '0;
         assign hld_valid = 1'b0;
      end
   endgenerate

   sdb_err_resp u_err (
      .clk   (MCLK),
      .rst_n (RST_N),
      .start (ev_perr),
      .resp  (err_resp),
      .ready (err_rdy)
   );

   // Current transfer register, loaded directly or from the hold stage
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         cur_vec <= '0;
         pend    <= 1'b0;
      end else if (load_cur) begin
         cur_vec <= cap_vec;
         pend    <= 1'b1;
      end else if (hld_take) begin
         cur_vec <= hld_vec;
         pend    <= 1'b1;
      end else if (issue) begin
         pend    <= 1'b0;
      end
   end

   // Fast data phase
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         fdp       <= 1'b0;
         fdp_buf   <= 1'b0;
         fdp_held  <= 1'b0;
         fdp_write <= 1'b0;
      end else if (acc) begin
         fdp       <= 1'b1;
         fdp_buf   <= cap_buf;
         fdp_held  <= busy;
         fdp_write <= HWRITES;
      end else if (hld_take) begin
         fdp_held  <= 1'b0;
      end else if (HREADYOUTS) begin
         fdp       <= 1'b0;
      end
   end

   // Write data is taken only for the transfer owning the slow side
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         wdata <= '0;
      end else if (fdp && !fdp_held && fdp_write && !err_resp) begin
         wdata <= HWDATAS;
      end
   end

   // Slow side sequencer, moves on enabled edges only
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         st         <= sdb_pkg::SL_IDLE;
         rem        <= 4'h0;
         HADDRM     <= '0;
         HTRANSM    <= sdb_pkg::TRANS_IDLE;
         HSIZEM     <= 3'h0;
         HBURSTM    <= sdb_pkg::BURST_SINGLE;
         HPROTM     <= 4'h0;
         HMASTERM   <= '0;
         HWRITEM    <= 1'b0;
         HMASTLOCKM <= 1'b0;
         HWDATAM    <= '0;
      end else if (en) begin
         case (st)
            sdb_pkg::SL_IDLE: begin
               if (pend) begin
                  st         <= sdb_pkg::SL_ADDR;
                  rem        <= next_rem;
                  HADDRM     <= c_addr;
                  HTRANSM    <= issue_trans;
                  HSIZEM     <= c_size;
                  HBURSTM    <= issue_burst;
                  HPROTM     <= c_prot;
                  HMASTERM   <= c_master;
                  HWRITEM    <= c_write;
                  HMASTLOCKM <= c_lock;
               end
            end
            sdb_pkg::SL_ADDR: begin
               if (HREADYM) begin
                  st      <= sdb_pkg::SL_DATA;
                  HWDATAM <= wdata;
                  HTRANSM <= gap_busy ? sdb_pkg::TRANS_BUSY : sdb_pkg::TRANS_IDLE;
               end
            end
            default: begin
               if (HREADYM || HRESPM) begin
                  st <= sdb_pkg::SL_IDLE;
                  if (HRESPM) begin
                     HTRANSM <= sdb_pkg::TRANS_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Fault pulse for buffered writes
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         BUFFERED_WRITE_FAULT_PULSE <= 1'b0;
      end else begin
         BUFFERED_WRITE_FAULT_PULSE <= ev_bwf;
      end
   end

   // APB register decode
   wire logic apb_setup  = PSEL && !PENABLE;
   wire logic apb_access = PSEL && PENABLE && PREADY;
   wire logic sel_status = (PADDR == sdb_pkg::STATUS_OFF);
   wire logic sel_mask   = (PADDR == sdb_pkg::MASK_OFF);
   wire logic sel_state  = (PADDR == sdb_pkg::STATE_OFF);
   wire logic mapped     = sel_status || sel_mask || sel_state;
   wire logic [31:0] state_word = {29'h0, pend, (st != sdb_pkg::SL_IDLE), hld_valid};
   wire logic [31:0] rd_mux = sel_status ? {30'h0, status}
                            : sel_mask   ? {30'h0, mask}
                            : sel_state  ? state_word : 32'h0;
   wire logic [sdb_pkg::EV_W-1:0] rd_clr = (apb_access && !PWRITE && sel_status)
                                           ? PRDATA[sdb_pkg::EV_W-1:0]
                                           : {sdb_pkg::EV_W{1'b0}};
   wire logic [sdb_pkg::EV_W-1:0] events = {ev_perr, ev_bwf};

   // Only bits seen by the read are cleared; new events win
   assign next_status = (status & ~rd_clr) | events;

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= apb_setup;
         PSLVERR <= apb_setup && !mapped;
         if (apb_setup) begin
            PRDATA <= rd_mux;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         status    <= sdb_pkg::STATUS_RST;
         mask      <= sdb_pkg::MASK_RST;
         INTERRUPT <= 1'b0;
      end else begin
         status    <= next_status;
         INTERRUPT <= |(next_status & mask);
         if (apb_access && PWRITE && sel_mask && PSTRB[0]) begin
            mask <= PWDATA[sdb_pkg::EV_W-1:0];
         end
      end
   end

endmodule

// [sdb_bridge_chk_sva.sv]
`timescale 1ns/100ps
module sdb_bridge_chk (
   // Clock and reset
   input wire logic        MCLK,
   input wire logic        RST_N,
   input wire logic        SLOW_BUS_CLOCK_ENABLE,
   // Fast side
   input wire logic        HSELS,
   input wire logic [1:0]  HTRANSS,
   input wire logic        HWRITES,
   input wire logic        HREADYS,
   input wire logic        HREADYOUTS,
   input wire logic        HRESPS,
   input wire logic [31:0] HRDATAS,
   input wire logic        BUFFERED_WRITE_FAULT_PULSE,
   // Slow side
   input wire logic [31:0] HADDRM,
   input wire logic [1:0]  HTRANSM,
   input wire logic [2:0]  HBURSTM,
   input wire logic [31:0] HRDATAM,
   input wire logic        HRESPM
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   logic taken;
   assign taken = HSELS && HTRANSS[1] && HREADYS;

   fwd_stable_a: assert property (
      $past(RST_N) && !$past(SLOW_BUS_CLOCK_ENABLE) |-> $stable(HADDRM) && $stable(HTRANSM))
      else $error("slow side moved off an enabled edge");
   read_late_a: assert property (
      taken && !HWRITES |=> !HREADYOUTS) else $error("read answered without registering");
   rdata_pass_a: assert property (
      HRDATAS == HRDATAM) else $error("read data not passed straight back");
   err_two_a: assert property (
      $rose(HRESPS) |-> !HREADYOUTS ##1 (HRESPS && HREADYOUTS))
      else $error("error response not two cycles");
   err_cause_a: assert property (
      $rose(HRESPS) |-> $past(HRESPM && SLOW_BUS_CLOCK_ENABLE))
      else $error("error response without slow error");
   pulse_one_a: assert property (
      BUFFERED_WRITE_FAULT_PULSE |=> !BUFFERED_WRITE_FAULT_PULSE)
      else $error("fault pulse longer than one cycle");
   pulse_cause_a: assert property (
      $rose(BUFFERED_WRITE_FAULT_PULSE) |-> !HRESPS &&
      ($past(HRESPM) || $past(HRESPM, 2) || $past(HRESPM, 3)))
      else $error("fault pulse without slow error");
   single_fwd_a: assert property (
      HTRANSM != sdb_pkg::TRANS_SEQ && HBURSTM == sdb_pkg::BURST_SINGLE)
      else $error("burst reached the slow side");
   idle_reset_a: assert property (
      $rose(RST_N) |-> HTRANSM == sdb_pkg::TRANS_IDLE && HREADYOUTS && !HRESPS &&
      !BUFFERED_WRITE_FAULT_PULSE) else $error("not idle after reset");

   cover property (taken && HWRITES);
   cover property ($rose(HRESPS));
   cover property (BUFFERED_WRITE_FAULT_PULSE);
endmodule

// [sdb_slow_model.sv]
`timescale 1ns/100ps
module sdb_slow_model (
   // Clock and slow enable
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        en,
   // Slow AHB from the bridge
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   // Behaviour controls
   input  wire logic [1:0]  waits,
   input  wire logic [31:0] err_addr,
   // Answers and record
   output logic             hready,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic [31:0]      wr_addr,
   output logic [31:0]      wr_data,
   output logic [7:0]       done_cnt
);
   logic        dp;
   logic        w;
   logic        er;
   logic        fail;
   logic [1:0]  cnt;
   logic [31:0] a;
   logic [31:0] cyc;
   assign fail = dp && a == err_addr && cnt == 2'h0;
   assign hready = !dp || (cnt == 2'h0 && (!fail || er));
   assign hresp = fail;
   // Data lines churn whenever no valid read data is due
   assign hrdata = (dp && !w && hready && !fail) ? a ^ 32'h5a5a_0000 : cyc;

   always_ff @(posedge clk) begin
      cyc <= cyc + 32'h1;
      if (!rst_n) begin
         cyc <= 32'h0;
         dp <= 1'b0;
         er <= 1'b0;
         done_cnt <= 8'h0;
      end else if (en) begin
         if (dp && cnt != 2'h0)
            cnt <= cnt - 2'h1;
         else if (fail && !er)
            er <= 1'b1;
         else begin
            if (dp)
               done_cnt <= done_cnt + 8'h1;
            if (dp && w) begin
               wr_addr <= a;
               wr_data <= hwdata;
            end
            dp <= htrans[1];
            a <= haddr;
            w <= hwrite;
            cnt <= waits;
            er <= 1'b0;
         end
      end
   end
endmodule

// [ahb_sync_down_bridge_tb_top.sv]
`timescale 1ns/100ps
module ahb_sync_down_bridge_tb_top;
   typedef struct packed {
      logic [31:0] a;
      logic        w;
      logic        p;
      logic [31:0] d;
      logic [1:0]  wt;
      logic        rs;
   } sdb_row_t;
   logic MCLK = 1'b0, RST_N = 1'b0, SLOW_BUS_CLOCK_ENABLE = 1'b0;
   logic HSELS = 1'b0, HWRITES = 1'b0, HMASTLOCKS = 1'b0, HMASTERS = 1'b1;
   logic [31:0] HADDRS = 32'h0, HWDATAS = 32'h0, HRDATAS, HADDRM, HWDATAM, HRDATAM;
   logic [1:0]  HTRANSS = 2'h0, HTRANSM, div = 2'h3, dcnt = 2'h0, waits = 2'h0;
   logic [2:0]  HSIZES = 3'h2, HBURSTS = sdb_pkg::BURST_INCR, HSIZEM, HBURSTM;
   logic [3:0]  HPROTS = 4'h0, HPROTM, PSTRB = 4'hf;
   logic HREADYOUTS, HRESPS, BUFFERED_WRITE_FAULT_PULSE, HMASTERM, HWRITEM, HMASTLOCKM;
   logic HREADYM, HRESPM, PREADY, PSLVERR, INTERRUPT, rs_q;
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h0;
   logic [31:0] PWDATA = 32'h0, PRDATA, wr_addr, wr_data, rd_q;
   logic [7:0]  done_cnt, n0;
   wire logic   HREADYS;
   int err_total = 0, total_checks = 0, pulses = 0, cyc = 0, lat, p0;
   sdb_row_t r;
   sdb_row_t rows [6] = '{'{32'h100, 1'b0, 1'b0, 32'h0, 2'h0, 1'b0},
      '{32'h104, 1'b1, 1'b0, 32'h1111_2222, 2'h1, 1'b0},
      '{32'h108, 1'b0, 1'b1, 32'h0, 2'h2, 1'b0},
      '{32'h10c, 1'b1, 1'b1, 32'habcd_0001, 2'h2, 1'b0},
      '{32'h1e0, 1'b0, 1'b0, 32'h0, 2'h0, 1'b1},
      '{32'h1e0, 1'b1, 1'b0, 32'h5555_aaaa, 2'h1, 1'b1}};
   assign HREADYS = HREADYOUTS;

   sdb_bridge #(.write_buffer_param(1)) sdb_bridge_inst (.*);
   sdb_slow_model sdb_slow_model_inst (.clk(MCLK), .rst_n(RST_N),
      .en(SLOW_BUS_CLOCK_ENABLE), .haddr(HADDRM), .htrans(HTRANSM), .hwrite(HWRITEM),
      .hwdata(HWDATAM), .waits(waits), .err_addr(32'h1e0), .hready(HREADYM),
      .hresp(HRESPM), .hrdata(HRDATAM), .wr_addr(wr_addr), .wr_data(wr_data),
      .done_cnt(done_cnt));

   always #2.5 MCLK = ~MCLK;
   always @(posedge MCLK) begin
      dcnt <= (dcnt >= div - 2'h1) ? 2'h0 : dcnt + 2'h1;
      SLOW_BUS_CLOCK_ENABLE <= (dcnt >= div - 2'h1);
      if (BUFFERED_WRITE_FAULT_PULSE === 1'b1)
         pulses <= pulses + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic wait_rdy(output int n);
      n = 0;
      do begin
         @(negedge MCLK);
         n++;
      end while (HREADYOUTS !== 1'b1);
      rd_q = HRDATAS;
      rs_q = HRESPS;
      @(posedge MCLK);
   endtask

   task automatic ahb(input logic [31:0] a, input logic w, p, input logic [31:0] d);
      int n;
      HSELS <= 1'b1;
      HTRANSS <= sdb_pkg::TRANS_NONSEQ;
      HADDRS <= a;
      HWRITES <= w;
      HPROTS <= {1'b0, p, 2'h3};
      wait_rdy(n);
      HSELS <= 1'b0;
      HTRANSS <= sdb_pkg::TRANS_IDLE;
      HWDATAS <= d;
      wait_rdy(lat);
   endtask

   task automatic wait_done(input logic [7:0] t);
      int n;
      n = 0;
      do begin
         @(negedge MCLK);
         n++;
      end while (done_cnt !== t && n < 300);
      @(posedge MCLK);
      chk(done_cnt, t);
   endtask

   task automatic reg_chk(input logic w, input logic [11:0] a, input logic [31:0] d, e,
                          input logic ee);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      // Answer taken at the edge where pready is sampled high
      do begin
         @(posedge MCLK);
      end while (PREADY !== 1'b1);
      if (!w) chk(PRDATA, e);
      chk(PSLVERR, ee);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge MCLK);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge MCLK);
      RST_N <= 1'b1;
      @(posedge MCLK);
      for (int k = 0; k < 12; k++) begin
         r = rows[k % 6];
         div <= (k < 6) ? 2'h1 : 2'h3;
         waits <= r.wt;
         n0 = done_cnt;
         ahb(r.a, r.w, r.p, r.d);
         chk(rs_q, r.rs);
         if (!r.w && !r.rs) chk(rd_q, r.a ^ 32'h5a5a_0000);
         chk(lat == 1, r.w && r.p);
         wait_done(n0 + 8'h1);
         if (r.w && !r.rs) chk(wr_data, r.d);
         if (r.w && !r.rs) chk(wr_addr, r.a);
         chk({HSIZEM, HPROTM, HMASTERM, HMASTLOCKM, HWRITEM},
             {3'h2, 1'b0, r.p, 2'h3, 2'h2, r.w});
         $display("row %0d done", k);
      end
      reg_chk(1'b0, sdb_pkg::STATUS_OFF, 32'h0, 32'h2, 1'b0);
      reg_chk(1'b0, sdb_pkg::STATUS_OFF, 32'h0, 32'h0, 1'b0);
      reg_chk(1'b0, 12'h00c, 32'h0, 32'h0, 1'b1);
      reg_chk(1'b1, sdb_pkg::MASK_OFF, 32'h3, 32'h0, 1'b0);
      reg_chk(1'b0, sdb_pkg::MASK_OFF, 32'h0, 32'h3, 1'b0);
      $display("registers done");
      p0 = pulses;
      n0 = done_cnt;
      ahb(32'h1e0, 1'b1, 1'b1, 32'h0bad_0bad);
      chk(rs_q, 1'b0);
      chk(lat, 1);
      wait_done(n0 + 8'h1);
      for (int i = 0; i < 40 && pulses == p0; i++) @(posedge MCLK);
      repeat (3) @(posedge MCLK);
      chk(pulses - p0, 1);
      chk(INTERRUPT, 1'b1);
      reg_chk(1'b0, sdb_pkg::STATUS_OFF, 32'h0, 32'h1, 1'b0);
      chk(INTERRUPT, 1'b0);
      $display("buffered fault done");
      waits <= 2'h2;
      ahb(32'h110, 1'b1, 1'b1, 32'h1357_9bdf);
      chk(lat, 1);
      ahb(32'h114, 1'b0, 1'b0, 32'h0);
      chk(lat > 2, 1'b1);
      chk(wr_addr, 32'h110);
      chk(rd_q, 32'h5a5a_0114);
      $display("held transfer done");
      RST_N <= 1'b0;
      repeat (12) @(posedge MCLK);
      RST_N <= 1'b1;
      @(negedge MCLK);
      chk({HREADYOUTS, HRESPS, BUFFERED_WRITE_FAULT_PULSE, INTERRUPT}, 4'h8);
      @(posedge MCLK);
      reg_chk(1'b0, sdb_pkg::MASK_OFF, 32'h0, 32'h0, 1'b0);
      reg_chk(1'b0, sdb_pkg::STATE_OFF, 32'h0, 32'h0, 1'b0);
      $display("reset done");
      tally_and_finish();
   end
endmodule

bind sdb_bridge sdb_bridge_chk sdb_bridge_chk_inst (.*);
